// ==== hw/sbkc_pkg.sv ====
/*
 Package of the serial boot key check: storage addresses, reserved words,
 protect value, link word and verdict structs and states.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package sbkc_pkg;
   localparam int KEY_BYTES = 7;
   localparam logic [19:0] KEY_ADDR_FIRST = 20'hFFFDF;
   localparam logic [19:0] KEY_ADDR_SECOND = 20'hFFFE3;
   localparam logic [19:0] KEY_ADDR_THIRD = 20'hFFFEB;
   localparam logic [19:0] KEY_ADDR_FOURTH = 20'hFFFEF;
   localparam logic [19:0] KEY_ADDR_FIFTH = 20'hFFFF3;
   localparam logic [19:0] KEY_ADDR_SIXTH = 20'hFFFF7;
   localparam logic [19:0] KEY_ADDR_SEVENTH = 20'hFFFFB;
   localparam logic [55:0] FORCED_ERASE_KEYWORD = 56'h414C6552415345;
   localparam logic [55:0] LOCKOUT_KEYWORD = 56'h50726F74656374;
   localparam logic [1:0] PROTECT_OPEN = 2'h3;
   localparam int BYTE_W = 8;
   localparam int FIFO_DEPTH = 8;

   typedef struct packed {
      logic is_cmd;
      logic [7:0] data;
   } sbkc_word_t;

   typedef struct packed {
      logic allow;
      logic erase_all;
      logic mismatch;
      logic lockout;
      logic protect_locked;
   } sbkc_verdict_t;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_FETCH = 6'h02,
      ST_RECV = 6'h04,
      ST_DECIDE = 6'h08,
      ST_PASS = 6'h10,
      ST_BLOCK = 6'h20
   } sbkc_state_t;
endpackage

// ==== hw/sbkc_fifo.sv ====
/*
 Synchronous FIFO with valid and ready on both sides.
 Assumes a single clock domain, active-low synchronous reset.
*/
`timescale 1ns/1ps
module sbkc_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic full;
   logic empty;
   assign empty = (wr_q == rd_q);
   assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign o_in_ready = !full;
   assign o_out_valid = !empty;
   assign o_out_data = mem[rd_q[AW-1:0]];

   always_ff @(posedge i_clk) begin
      if (i_ce && i_in_valid && !full) begin
         mem[wr_q[AW-1:0]] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else if (i_ce) begin
         if (i_in_valid && !full) wr_q <= wr_q + 1'b1;
         if (i_out_ready && !empty) rd_q <= rd_q + 1'b1;
      end
   end
endmodule

// ==== hw/sbkc_top.sv ====
/*
 Serial boot key check gate: boot mode strap capture, synchronous link
 receiver on the link clock, key fetch from storage, verdict and command gate.
 Assumes storage answers a read one cycle after the request, and the link
 clock runs only while the programmer drives it.
*/
`timescale 1ns/1ps
module sbkc_top
   import sbkc_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   input wire logic i_link_clk,
   input wire logic i_boot_select_pin,
   input wire logic i_chip_enable_pin,
   input wire logic i_boot_link_clock_pin,
   input wire logic i_boot_link_receive_pin,
   input wire logic [1:0] i_code_protect_field,
   output logic o_key_rd_req,
   output logic [19:0] o_key_rd_addr,
   input wire logic [7:0] i_key_rd_data,
   output logic o_boot_link_busy_pin,
   output logic o_boot_link_transmit_pin,
   output logic o_serial_boot,
   output logic o_sync_mode,
   output logic o_erase_all,
   output logic o_key_mismatch,
   output logic o_lockout,
   output logic o_unprotect_refused,
   output logic o_cmd_valid,
   output logic [7:0] o_cmd_data,
   input wire logic i_cmd_ready
);
   initial begin
      if (DEPTH != FIFO_DEPTH) $error("DEPTH must match the documented buffer");
   end

   // Link-clock receiver: byte per 8 edges, toggle per byte
   // Link regs have no reset; start values keep the bit count aligned
   logic [2:0] rx_cnt_q = 3'h0;
   logic [7:0] rx_sh_q;
   logic [7:0] rx_byte_q;
   logic rx_tog_q = 1'b0;
   logic [3:0] rx_tog_sync_q;
   logic [1:0] strap_sync_q [3];
   logic [7:0] rx_data_s1_q;
   logic [7:0] rx_data_q;

   always_ff @(posedge i_link_clk) begin
      if (rx_cnt_q == 3'h7) begin
         rx_byte_q <= {rx_sh_q[6:0], i_boot_link_receive_pin};
         rx_tog_q <= ~rx_tog_q;
      end
      rx_sh_q <= {rx_sh_q[6:0], i_boot_link_receive_pin};
      rx_cnt_q <= rx_cnt_q + 3'h1;
   end

   // Pin and toggle synchronisers
   always_ff @(posedge i_clk) begin
      if (i_ce) begin
         rx_tog_sync_q <= {rx_tog_sync_q[2:0], rx_tog_q};
         rx_data_s1_q <= rx_byte_q;
         rx_data_q <= rx_data_s1_q;
         strap_sync_q[0] <= {strap_sync_q[0][0], i_boot_select_pin};
         strap_sync_q[1] <= {strap_sync_q[1][0], i_chip_enable_pin};
         strap_sync_q[2] <= {strap_sync_q[2][0], i_boot_link_clock_pin};
      end
   end
   // Event one stage late, so the byte was sampled while stable
   logic rx_event;
   assign rx_event = rx_tog_sync_q[3] ^ rx_tog_sync_q[2];

   logic strap_done_q;
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         strap_done_q <= 1'b0;
         o_serial_boot <= 1'b0;
         o_sync_mode <= 1'b0;
      end else if (i_ce && !strap_done_q) begin
         strap_done_q <= 1'b1;
         o_serial_boot <= strap_sync_q[0][1] && strap_sync_q[1][1];
         o_sync_mode <= strap_sync_q[2][1];
      end
   end

   sbkc_state_t state_q;
   logic [2:0] idx_q;
   logic [55:0] stored_q;
   logic [55:0] sent_q;
   logic fetch_wait_q;
   sbkc_verdict_t verdict_q;
   logic [19:0] key_addr [KEY_BYTES];
   assign key_addr[0] = KEY_ADDR_FIRST;
   assign key_addr[1] = KEY_ADDR_SECOND;
   assign key_addr[2] = KEY_ADDR_THIRD;
   assign key_addr[3] = KEY_ADDR_FOURTH;
   assign key_addr[4] = KEY_ADDR_FIFTH;
   assign key_addr[5] = KEY_ADDR_SIXTH;
   assign key_addr[6] = KEY_ADDR_SEVENTH;

   logic stored_erase;
   logic stored_lock;
   logic sent_erase;
   logic protect_open;
   assign stored_erase = (stored_q == FORCED_ERASE_KEYWORD);
   assign stored_lock = (stored_q == LOCKOUT_KEYWORD);
   assign sent_erase = (sent_q == FORCED_ERASE_KEYWORD);
   assign protect_open = (i_code_protect_field == PROTECT_OPEN);

   logic fifo_in_ready;
   logic fifo_out_valid;
   sbkc_word_t fifo_out;
   logic fifo_in_valid;
   assign fifo_in_valid = rx_event && (state_q == ST_PASS);

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         state_q <= ST_IDLE;
         idx_q <= 3'h0;
         stored_q <= '0;
         sent_q <= '0;
         fetch_wait_q <= 1'b0;
         verdict_q <= '0;
         o_key_rd_req <= 1'b0;
         o_key_rd_addr <= '0;
      end else if (i_ce) begin
         o_key_rd_req <= 1'b0;
         unique case (state_q)
            ST_IDLE: begin
               if (strap_done_q && o_serial_boot) begin
                  state_q <= ST_FETCH;
                  idx_q <= 3'h0;
               end
            end
            ST_FETCH: begin
               if (!fetch_wait_q) begin
                  o_key_rd_req <= 1'b1;
                  o_key_rd_addr <= key_addr[idx_q];
                  fetch_wait_q <= 1'b1;
               end else if (!o_key_rd_req) begin
                  fetch_wait_q <= 1'b0;
                  stored_q <= {stored_q[47:0], i_key_rd_data};
                  if (idx_q == 3'h6) begin
                     idx_q <= 3'h0;
                     state_q <= ST_RECV;
                  end else begin
                     idx_q <= idx_q + 3'h1;
                  end
               end
            end
            ST_RECV: begin
               if (stored_lock) begin
                  state_q <= ST_DECIDE;
               end else if (rx_event) begin
                  sent_q <= {sent_q[47:0], rx_data_q};
                  if (idx_q == 3'h6) state_q <= ST_DECIDE;
                  idx_q <= idx_q + 3'h1;
               end
            end
            ST_DECIDE: begin
               verdict_q <= '0;
               state_q <= ST_BLOCK;
               if (stored_lock) begin
                  verdict_q.lockout <= 1'b1;
                  verdict_q.protect_locked <= !protect_open;
               end else if (sent_erase && (stored_erase || protect_open)) begin
                  verdict_q.erase_all <= 1'b1;
                  verdict_q.allow <= 1'b1;
                  state_q <= ST_PASS;
               end else if (stored_erase) begin
                  verdict_q.mismatch <= 1'b1;
               end else if (sent_q == stored_q) begin
                  verdict_q.allow <= 1'b1;
                  state_q <= ST_PASS;
               end else begin
                  verdict_q.mismatch <= 1'b1;
               end
            end
            ST_PASS: state_q <= ST_PASS;
            ST_BLOCK: state_q <= ST_BLOCK;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Command buffer ahead of the flash sequencer
   sbkc_fifo #(.WIDTH($bits(sbkc_word_t)), .DEPTH(DEPTH)) u_fifo (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_ce(i_ce),
      .i_in_valid(fifo_in_valid),
      .o_in_ready(fifo_in_ready),
      .i_in_data({1'b1, rx_data_q}),
      .o_out_valid(fifo_out_valid),
      .i_out_ready(i_cmd_ready && !o_cmd_valid),
      .o_out_data(fifo_out)
   );

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_cmd_valid <= 1'b0;
         o_cmd_data <= 8'h00;
      end else if (i_ce) begin
         if (o_cmd_valid && i_cmd_ready) begin
            o_cmd_valid <= 1'b0;
         end else if (!o_cmd_valid && fifo_out_valid && i_cmd_ready && verdict_q.allow) begin
            o_cmd_valid <= 1'b1;
            o_cmd_data <= fifo_out.data;
         end
      end
   end

   // Verdict outputs, busy and monitor pin
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_erase_all <= 1'b0;
         o_key_mismatch <= 1'b0;
         o_lockout <= 1'b0;
         o_unprotect_refused <= 1'b0;
         o_boot_link_busy_pin <= 1'b1;
         o_boot_link_transmit_pin <= 1'b1;
      end else if (i_ce) begin
         o_erase_all <= verdict_q.erase_all && (state_q == ST_PASS);
         o_key_mismatch <= verdict_q.mismatch;
         o_lockout <= verdict_q.lockout;
         o_unprotect_refused <= verdict_q.protect_locked;
         o_boot_link_transmit_pin <= 1'b1;
         if (o_sync_mode) begin
            o_boot_link_busy_pin <= !((state_q == ST_RECV && !stored_lock) ||
                                      (state_q == ST_PASS && fifo_in_ready));
         end else begin
            o_boot_link_busy_pin <= o_serial_boot && (state_q != ST_BLOCK);
         end
      end
   end

   // Assertions
   sequence s_decide;
      state_q == ST_DECIDE;
   endsequence
   property p_lock;
      @(posedge i_clk) disable iff (!i_nrst)
      (s_decide and (i_ce && stored_lock)) |=> (state_q == ST_BLOCK) && verdict_q.lockout;
   endproperty
   a_lock: assert property (p_lock) else $error("lockout not taken");
   property p_erase;
      @(posedge i_clk) disable iff (!i_nrst)
      (s_decide and (i_ce && !stored_lock && sent_erase && stored_erase)) |=> verdict_q.erase_all;
   endproperty
   a_erase: assert property (p_erase) else $error("forced erase missed");
   property p_erase_prot;
      @(posedge i_clk) disable iff (!i_nrst)
      (s_decide and (i_ce && !stored_lock && sent_erase && !stored_erase && !protect_open))
         |=> !verdict_q.erase_all;
   endproperty
   a_erase_prot: assert property (p_erase_prot) else $error("erase despite protect");
   property p_mis;
      @(posedge i_clk) disable iff (!i_nrst)
      (s_decide and (i_ce && stored_erase && !sent_erase)) |=> verdict_q.mismatch && !verdict_q.allow;
   endproperty
   a_mis: assert property (p_mis) else $error("mismatch not flagged");
   property p_refuse;
      @(posedge i_clk) disable iff (!i_nrst)
      (s_decide and (i_ce && stored_lock && !protect_open)) |=> verdict_q.protect_locked;
   endproperty
   a_refuse: assert property (p_refuse) else $error("unprotect not refused");
   property p_gate;
      @(posedge i_clk) disable iff (!i_nrst)
      $rose(o_cmd_valid) |-> $past(verdict_q.allow);
   endproperty
   a_gate: assert property (p_gate) else $error("command passed unchecked");
   property p_addr;
      @(posedge i_clk) disable iff (!i_nrst)
      (o_key_rd_req && idx_q == 3'h0) |-> o_key_rd_addr == KEY_ADDR_FIRST;
   endproperty
   a_addr: assert property (p_addr) else $error("wrong first key address");
   property p_busy;
      @(posedge i_clk) disable iff (!i_nrst)
      (i_ce && o_sync_mode && state_q == ST_BLOCK) |=> o_boot_link_busy_pin;
   endproperty
   a_busy: assert property (p_busy) else $error("busy low while blocked");
endmodule

// ==== verification/sbkc_prog_model.sv ====
/*
 Serial programmer model: clocks bytes onto the boot link, MSB first.
 Assumes the bench calls send_byte; the link clock stands low between frames.
*/
`timescale 1ns/1ps
module sbkc_prog_model (
   output logic o_link_clk,
   output logic o_rxd
);
   initial begin
      o_link_clk = 1'b0;
      o_rxd = 1'b1;
   end
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         o_rxd = b[i];
         #40 o_link_clk = 1'b1;
         #40 o_link_clk = 1'b0;
      end
      o_rxd = ~b[0];
      #200;
   endtask
endmodule

// ==== verification/testbench.sv ====
/*
 Self-checking bench of the boot key gate: key storage, programmer, commands.
 Assumes storage answers one cycle after a read request.
*/
`timescale 1ns/1ps
module testbench;
   import sbkc_pkg::*;
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic clkpin = 1'b1;
   logic bsel = 1'b1;
   logic cepin = 1'b1;
   logic ready = 1'b0;
   logic [1:0] prot = 2'h0;
   logic [7:0] key_data = 8'h00;
   logic link_clk, rxd, key_req, busy, txd, sboot, sync, erase, mism, lock, refused, cvalid;
   logic [19:0] key_addr;
   logic [7:0] cdata;
   logic [55:0] stored, nk;
   logic [31:0] seed = 32'h9EFDB7BC;
   logic [31:0] rseed = 32'h9EFDB7BC;
   logic [7:0] expq[$];
   logic [19:0] kaddr [7] = '{KEY_ADDR_FIRST, KEY_ADDR_SECOND, KEY_ADDR_THIRD, KEY_ADDR_FOURTH,
      KEY_ADDR_FIFTH, KEY_ADDR_SIXTH, KEY_ADDR_SEVENTH};
   int kidx = 0;
   int fail_count = 0;
   int cmp_count = 0;
   int cycles = 0;

   always #5 i_clk = ~i_clk;

   sbkc_prog_model prog (.o_link_clk(link_clk), .o_rxd(rxd));

   sbkc_top uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1), .i_link_clk(link_clk),
      .i_boot_select_pin(bsel), .i_chip_enable_pin(cepin), .i_boot_link_clock_pin(clkpin),
      .i_boot_link_receive_pin(rxd), .i_code_protect_field(prot), .o_key_rd_req(key_req),
      .o_key_rd_addr(key_addr), .i_key_rd_data(key_data), .o_boot_link_busy_pin(busy),
      .o_boot_link_transmit_pin(txd), .o_serial_boot(sboot), .o_sync_mode(sync), .o_erase_all(erase),
      .o_key_mismatch(mism), .o_lockout(lock), .o_unprotect_refused(refused), .o_cmd_valid(cvalid),
      .o_cmd_data(cdata), .i_cmd_ready(ready));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Storage answers the key fetch
   always @(posedge i_clk) begin
      if (key_req) begin
         check("key_addr", kaddr[kidx % 7], key_addr);
         key_data <= stored[55 - 8 * (kidx % 7) -: 8];
         kidx++;
      end else begin
         key_data <= ~key_data;
      end
   end

   // Random stalls on the command side
   always @(negedge i_clk) begin
      rseed = lfsr(rseed);
      ready <= rseed[0] | rseed[1];
   end

   // Command monitor
   always @(posedge i_clk) begin
      if (i_nrst && cvalid === 1'b1 && ready) begin
         if (expq.size() == 0)
            check("cmd_unexpected", 0, 1);
         else
            check("cmd_data", expq.pop_front(), cdata);
      end
   end

   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         final_report();
      end
   end

   task automatic reset_dut();
      @(negedge i_clk);
      i_nrst = 1'b0;
      kidx = 0;
      repeat (6) @(negedge i_clk);
      i_nrst = 1'b1;
      repeat (40) @(negedge i_clk);
   endtask

   task automatic run(input string name, input logic [55:0] st, input logic [55:0] se, input logic [1:0] pr);
      logic er, lk, ok;
      lk = (st == LOCKOUT_KEYWORD);
      er = (se == FORCED_ERASE_KEYWORD) && !lk && (st == se || pr == PROTECT_OPEN);
      ok = !lk && !er && (se == st);
      stored = st;
      prot = pr;
      reset_dut();
      check("serial_boot", 1, sboot);
      check("sync_mode", 1, sync);
      check("transmit_high", 1, txd);
      check("key_reads", 7, kidx);
      if (!lk) check("busy_ready", 0, busy);
      else check("busy_locked", 1, busy);
      for (int i = 6; i >= 0; i--) prog.send_byte(se[8 * i +: 8]);
      repeat (60) @(negedge i_clk);
      check("erase_all", er, erase);
      check("lockout", lk, lock);
      check("unprotect_refused", lk && pr != PROTECT_OPEN, refused);
      if (!lk) check("key_mismatch", !er && !ok, mism);
      if (!er) begin
         for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            if (ok) expq.push_back(seed[7:0]);
            prog.send_byte(seed[7:0]);
         end
      end
      repeat (60) @(negedge i_clk);
      check("cmd_left", 0, expq.size());
      $display("test %s done", name);
   endtask

   initial begin
      seed = lfsr(seed);
      nk = {seed[23:0], ~seed};
      stored = nk;
      run("erase_both", FORCED_ERASE_KEYWORD, FORCED_ERASE_KEYWORD, 2'h0);
      run("erase_open", nk, FORCED_ERASE_KEYWORD, 2'h3);
      run("erase_closed", nk, FORCED_ERASE_KEYWORD, 2'h0);
      run("stored_erase", FORCED_ERASE_KEYWORD, nk, 2'h3);
      run("normal_match", nk, nk, 2'h0);
      run("lock_closed", LOCKOUT_KEYWORD, LOCKOUT_KEYWORD, 2'h0);
      run("lock_open", LOCKOUT_KEYWORD, nk, 2'h3);
      clkpin = 1'b0;
      stored = nk;
      reset_dut();
      check("async_mode", 0, sync);
      check("async_monitor", 1, busy);
      $display("test async_mode done");
      cepin = 1'b0;
      reset_dut();
      check("no_boot_ce", 0, sboot);
      check("no_boot_monitor", 0, busy);
      cepin = 1'b1;
      bsel = 1'b0;
      reset_dut();
      check("no_boot_select", 0, sboot);
      check("no_boot_key_reads", 0, kidx);
      $display("test no_boot done");
      final_report();
   end
endmodule
